// [hdl/aph_pkg.sv]
// constants shared by both ends of the asynchronous parallel host port
package aph_pkg;

  // ------------------------------------------------------------------
  // widths and bus styles
  // ------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int REG_COUNT = 256;
  localparam logic [1:0] STYLE_SEPARATE = 2'h0;
  localparam logic [1:0] STYLE_DIRPIN = 2'h1;
  localparam logic [DATA_W-1:0] BUS_IDLE = 8'hFF;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int STROBE_TO_ACK_MAX_NS = 90;
  localparam int CS_TO_STROBE_MIN_NS = 65;
  // longest time rounds down, least time rounds up
  localparam int ACK_MAX_CYC = (STROBE_TO_ACK_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
                               STROBE_TO_ACK_MAX_NS / CLK_PERIOD_NS;
  localparam int CS_TO_STROBE_CYC = (CS_TO_STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(CS_TO_STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

endpackage : aph_pkg

// [hdl/aph_if.sv]
// pin-level interface joining the host end and the device end
`timescale 1ns/1ps
`default_nettype none
interface aph_if;
  import aph_pkg::*;

  logic chip_select_n;
  logic [ADDR_W-1:0] addr;
  logic address_strobe_in;
  logic read_or_data_strobe_pin;
  logic write_or_direction_pin;
  logic transfer_acknowledge_n;
  logic [DATA_W-1:0] data_host;
  logic data_host_oe;
  logic [DATA_W-1:0] data_dev;
  logic data_dev_oe;
  logic [DATA_W-1:0] data_bus;

  // level of the shared data wire, idle value when nobody drives
  assign data_bus = data_dev_oe ? data_dev : (data_host_oe ? data_host : BUS_IDLE);

  modport device (
    input chip_select_n, addr, address_strobe_in, read_or_data_strobe_pin,
    input write_or_direction_pin, data_bus,
    output transfer_acknowledge_n, data_dev, data_dev_oe
  );

  modport host (
    output chip_select_n, addr, address_strobe_in, read_or_data_strobe_pin,
    output write_or_direction_pin, data_host, data_host_oe,
    input transfer_acknowledge_n, data_bus
  );
endinterface : aph_if
`default_nettype wire

// [hdl/aph_host.sv]
// host end: turns user commands into pin-level register accesses
`timescale 1ns/1ps
`default_nettype none
module aph_host (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // pins
  aph_if.host pins,
  // user command
  input wire logic [1:0] bus_style_select_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [aph_pkg::ADDR_W-1:0] cmd_addr_in,
  input wire logic [aph_pkg::DATA_W-1:0] cmd_wdata_in,
  output logic cmd_ready_out,
  // user response
  output logic rsp_valid_out,
  output logic [aph_pkg::DATA_W-1:0] rsp_rdata_out
);
  import aph_pkg::*;

  typedef enum {H_IDLE, H_SETUP, H_STROBE, H_RELEASE, H_DONE} aph_host_state_t;

  aph_host_state_t state;
  logic [CNT_W-1:0] count;
  logic is_write;
  logic [1:0] style;
  logic ack_s1, ack_s2;
  logic [DATA_W-1:0] rd_s1, rd_s2;

  // ------------------------------------------------------------------
  // pin inputs through two flops
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ack_s1 <= 1'b1;
      ack_s2 <= 1'b1;
      rd_s1 <= BUS_IDLE;
      rd_s2 <= BUS_IDLE;
    end else begin
      ack_s1 <= pins.transfer_acknowledge_n;
      ack_s2 <= ack_s1;
      rd_s1 <= pins.data_bus;
      rd_s2 <= rd_s1;
    end
  end

  // ------------------------------------------------------------------
  // access sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= H_IDLE;
      count <= CNT_ZERO;
      is_write <= 1'b0;
      style <= STYLE_SEPARATE;
      cmd_ready_out <= 1'b1;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= REG_RESET;
      pins.chip_select_n <= 1'b1;
      pins.addr <= '0;
      pins.address_strobe_in <= 1'b0;
      pins.read_or_data_strobe_pin <= 1'b1;
      pins.write_or_direction_pin <= 1'b1;
      pins.data_host <= REG_RESET;
      pins.data_host_oe <= 1'b0;
    end else begin
      rsp_valid_out <= 1'b0;
      case (state)
        H_IDLE: begin
          if (cmd_valid_in) begin
            // address and select appear together
            pins.addr <= cmd_addr_in;
            pins.chip_select_n <= 1'b0;
            pins.address_strobe_in <= 1'b1;
            pins.data_host <= cmd_wdata_in;
            is_write <= cmd_write_in;
            style <= bus_style_select_in;
            cmd_ready_out <= 1'b0;
            count <= CNT_ZERO;
            state <= H_SETUP;
          end
        end
        H_SETUP: begin
          // strobe falls so the address is latched
          pins.address_strobe_in <= 1'b0;
          // write data driven on the edge the latch strobe falls, before the strobe
          pins.data_host_oe <= is_write;
          // direction set before the data strobe
          if (style == STYLE_DIRPIN) begin
            pins.write_or_direction_pin <= ~is_write;
          end
          count <= count + CNT_ONE;
          // select-to-strobe least time
          if (count == SETUP_LAST) begin
            if (style == STYLE_SEPARATE && is_write) begin
              pins.write_or_direction_pin <= 1'b0;
            end else begin
              pins.read_or_data_strobe_pin <= 1'b0;
            end
            state <= H_STROBE;
          end
        end
        H_STROBE: begin
          // end only after acknowledge seen and data taken
          if (!ack_s2) begin
            rsp_rdata_out <= is_write ? pins.data_host : rd_s2;
            pins.read_or_data_strobe_pin <= 1'b1;
            if (style == STYLE_SEPARATE) begin
              pins.write_or_direction_pin <= 1'b1;
            end
            state <= H_RELEASE;
          end
        end
        H_RELEASE: begin
          if (ack_s2) begin
            state <= H_DONE;
          end
        end
        H_DONE: begin
          pins.chip_select_n <= 1'b1;
          pins.data_host_oe <= 1'b0;
          pins.write_or_direction_pin <= 1'b1;
          rsp_valid_out <= 1'b1;
          cmd_ready_out <= 1'b1;
          state <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end

endmodule : aph_host
`default_nettype wire

// [hdl/aph_device.sv]
// device end: register file reached through the asynchronous host port
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - direction mode: address latched on strobe fall
// - direction pin high reads, low writes
// - access starts on strobe fall with select low
// - acknowledge low marks access finished
// - host drives address and select together
// - separate mode: address latched on strobe fall
// - latch strobe tied high: address passes through
// - read strobe low: drive selected register out
// - ready low within 90 ns of read
// - host ends read after ready seen
// - host puts write data before write strobe
// - write strobe low stores bus value
// - ready low within 90 ns of write
// - host waits 65 ns after select
// - address valid by select fall
// - host lowers address strobe after select
// - host holds direction high before read strobe
// - direction read: drive data and acknowledge on the same edge
// - host ends read after acknowledge seen
// - style input: 00 separate, 01 direction
// - select high: strobes ignored, no access
// - host holds direction low before write strobe
module aph_device (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // pins
  aph_if.device pins,
  // strap
  input wire logic [1:0] bus_style_select_in,
  // register write notification
  output logic reg_write_out,
  output logic [aph_pkg::ADDR_W-1:0] reg_write_addr_out,
  output logic [aph_pkg::DATA_W-1:0] reg_write_data_out,
  // status
  output logic busy_out
);
  import aph_pkg::*;

  typedef enum {ST_IDLE, ST_ACK} aph_dev_state_t;

  // ------------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------------
  // an access strobe is asserted in the current style
  function automatic logic aph_strobe_on(input logic [1:0] style,
                                         input logic rd_n,
                                         input logic wr_n);
    logic on;
    on = 1'b0;
    if (style == STYLE_SEPARATE) begin
      on = ~rd_n | ~wr_n;
    end else if (style == STYLE_DIRPIN) begin
      on = ~rd_n;
    end
    return on;
  endfunction : aph_strobe_on

  // the asserted strobe asks for a read
  function automatic logic aph_is_read(input logic [1:0] style,
                                       input logic rd_n,
                                       input logic wr_n);
    logic rd;
    rd = 1'b0;
    if (style == STYLE_SEPARATE) begin
      rd = ~rd_n;
    end else if (style == STYLE_DIRPIN) begin
      rd = wr_n;
    end
    return rd;
  endfunction : aph_is_read

  // ------------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------------
  localparam int SYNC_W = 4 + ADDR_W + DATA_W + 2;

  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic cs_n_s;
  logic ale_s;
  logic rd_n_s;
  logic wr_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic [1:0] style_s;
  logic strobe_prev;

  // every pin passes two flops before logic reads it
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync1 <= {4'hF, {(SYNC_W-4){1'b0}}};
      sync2 <= {4'hF, {(SYNC_W-4){1'b0}}};
    end else begin
      sync1 <= {pins.chip_select_n, pins.address_strobe_in,
                pins.read_or_data_strobe_pin, pins.write_or_direction_pin,
                pins.addr, pins.data_bus, bus_style_select_in};
      sync2 <= sync1;
    end
  end

  assign {cs_n_s, ale_s, rd_n_s, wr_n_s, addr_s, data_s, style_s} = sync2;

  // ------------------------------------------------------------------
  // access detection
  // ------------------------------------------------------------------
  logic strobe_now;
  logic start;
  logic start_read;

  assign strobe_now = aph_strobe_on(style_s, rd_n_s, wr_n_s);
  // only a fresh strobe fall under a low select counts
  assign start = ~cs_n_s & strobe_now & ~strobe_prev;
  assign start_read = aph_is_read(style_s, rd_n_s, wr_n_s);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      strobe_prev <= 1'b0;
    end else begin
      strobe_prev <= strobe_now;
    end
  end

  // ------------------------------------------------------------------
  // address latch
  // ------------------------------------------------------------------
  logic [ADDR_W-1:0] addr_latch;

  // follows the bus while the latch strobe is high and holds it from
  // the falling edge; a strobe tied high passes the bus straight on
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      addr_latch <= '0;
    end else if (ale_s) begin
      addr_latch <= addr_s;
    end
  end

  // ------------------------------------------------------------------
  // register file
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] regs [REG_COUNT];

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= REG_RESET;
      end
    end else if (start && !start_read) begin
      regs[addr_latch] <= data_s;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_write_out <= 1'b0;
      reg_write_addr_out <= '0;
      reg_write_data_out <= REG_RESET;
    end else begin
      reg_write_out <= start & ~start_read;
      if (start && !start_read) begin
        reg_write_addr_out <= addr_latch;
        reg_write_data_out <= data_s;
      end
    end
  end

  // ------------------------------------------------------------------
  // handshake
  // ------------------------------------------------------------------
  aph_dev_state_t state;

  // answer lands on the third edge after the pin falls, inside the
  // maximum strobe-to-acknowledge count of ACK_MAX_CYC
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= ST_IDLE;
      pins.transfer_acknowledge_n <= 1'b1;
      pins.data_dev_oe <= 1'b0;
      pins.data_dev <= REG_RESET;
      busy_out <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            if (start_read) begin
              // drive selected register on the same edge as the acknowledge
              pins.data_dev <= regs[addr_latch];
              pins.data_dev_oe <= 1'b1;
            end
            // acknowledge on the same edge that drives the data or stores the value
            pins.transfer_acknowledge_n <= 1'b0;
            busy_out <= 1'b1;
            state <= ST_ACK;
          end
        end
        ST_ACK: begin
          // strobe or select back high ends the access
          if (cs_n_s || !strobe_now) begin
            pins.transfer_acknowledge_n <= 1'b1;
            pins.data_dev_oe <= 1'b0;
            busy_out <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule : aph_device
`default_nettype wire

// [dv/aph_chk.sv]
// pin-level checker for the link between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
module aph_chk (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // link pins
  input wire logic chip_select_n,
  input wire logic read_or_data_strobe_pin,
  input wire logic write_or_direction_pin,
  input wire logic transfer_acknowledge_n,
  input wire logic [aph_pkg::DATA_W-1:0] data_dev,
  input wire logic data_dev_oe
);
  import aph_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  property p_idle_cs;
    chip_select_n [*4] |-> transfer_acknowledge_n;
  endproperty
  property p_ack_needs_cs;
    $fell(transfer_acknowledge_n) |-> !chip_select_n && !$past(chip_select_n, 3);
  endproperty
  property p_ack_in_time;
    $fell(read_or_data_strobe_pin) && !chip_select_n |-> ##[1:3] !transfer_acknowledge_n;
  endproperty
  property p_ack_holds;
    !transfer_acknowledge_n && !chip_select_n && !read_or_data_strobe_pin
      |=> !transfer_acknowledge_n;
  endproperty
  property p_ack_release;
    $rose(read_or_data_strobe_pin) |-> ##[1:3] transfer_acknowledge_n;
  endproperty
  property p_oe_with_ack;
    data_dev_oe |-> !transfer_acknowledge_n;
  endproperty
  property p_oe_release;
    $rose(transfer_acknowledge_n) |-> !data_dev_oe;
  endproperty
  property p_data_steady;
    data_dev_oe && $past(data_dev_oe) |-> $stable(data_dev);
  endproperty
  property p_ack_min;
    $fell(transfer_acknowledge_n) |-> !transfer_acknowledge_n [*4];
  endproperty

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  a_idle_cs: assert property (p_idle_cs)
    else $error("acknowledge low while select idle");
  a_ack_needs_cs: assert property (p_ack_needs_cs)
    else $error("acknowledge without select held low");
  a_ack_in_time: assert property (p_ack_in_time)
    else $error("acknowledge late after strobe");
  a_ack_holds: assert property (p_ack_holds)
    else $error("acknowledge dropped while strobe held");
  a_ack_release: assert property (p_ack_release)
    else $error("acknowledge not released after strobe end");
  a_oe_with_ack: assert property (p_oe_with_ack)
    else $error("data driven without acknowledge");
  a_oe_release: assert property (p_oe_release)
    else $error("data still driven after release");
  a_data_steady: assert property (p_data_steady)
    else $error("read data changed while driven");
  a_ack_min: assert property (p_ack_min)
    else $error("acknowledge pulse too short");

  // ------------------------------------------------------------------
  // coverage
  // ------------------------------------------------------------------
  c_read: cover property ($rose(data_dev_oe));
  c_write: cover property ($fell(transfer_acknowledge_n) && !write_or_direction_pin);
  c_back: cover property ($rose(chip_select_n) ##[1:3] $fell(chip_select_n));
endmodule : aph_chk
`default_nettype wire

// [dv/tb_async_parallel_host_port.sv]
// self-checking bench for both ends of the asynchronous parallel host port
`timescale 1ns/1ps
`default_nettype none
module tb_async_parallel_host_port;
  import aph_pkg::*;
  logic clk_in, reset_in, cmd_valid, cmd_write, cmd_ready, rsp_valid, dev_wr, side_wr, side_busy;
  logic [1:0] style, side_style;
  logic [7:0] cmd_addr, cmd_wdata, rsp_rdata, wr_addr, wr_data, side_addr, side_data, q;
  int bad_count = 0, samples_checked = 0, cycles = 0, wr_seen = 0, side_seen = 0;
  aph_if link();
  aph_if side_if();

  aph_host i_aph_host (.clk_in(clk_in), .reset_in(reset_in), .pins(link),
    .bus_style_select_in(style), .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write),
    .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata), .cmd_ready_out(cmd_ready),
    .rsp_valid_out(rsp_valid), .rsp_rdata_out(rsp_rdata));
  aph_device i_aph_device (.clk_in(clk_in), .reset_in(reset_in), .pins(link),
    .bus_style_select_in(style), .reg_write_out(dev_wr), .reg_write_addr_out(wr_addr),
    .reg_write_data_out(wr_data), .busy_out());
  // second device driven straight from the bench to break the host side rules
  aph_device i_aph_device_side (.clk_in(clk_in), .reset_in(reset_in), .pins(side_if),
    .bus_style_select_in(side_style), .reg_write_out(side_wr), .reg_write_addr_out(side_addr),
    .reg_write_data_out(side_data), .busy_out(side_busy));
  aph_chk i_aph_chk (.clk_in(clk_in), .reset_in(reset_in),
    .chip_select_n(link.chip_select_n), .read_or_data_strobe_pin(link.read_or_data_strobe_pin),
    .write_or_direction_pin(link.write_or_direction_pin),
    .transfer_acknowledge_n(link.transfer_acknowledge_n), .data_dev(link.data_dev),
    .data_dev_oe(link.data_dev_oe));

  // ------------------------------------------------------------------
  // clock, timeout and write monitors
  // ------------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (dev_wr === 1'b1) wr_seen++;
    if (side_wr === 1'b1) side_seen++;
    if (cycles == 3000) begin
      bad_count++;
      finish_test();
    end
  end

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check8

  task automatic host_cmd(input logic [1:0] st, input logic wr, input logic [7:0] a, d);
    int n;
    if (style !== st) begin
      style = st;
      repeat (3) @(posedge clk_in);
      #1;
    end
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_wdata = d;
    @(posedge clk_in);
    #1 cmd_valid = 1'b0;
    check8(8'(cmd_ready), 8'h00);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 40) begin
      @(posedge clk_in);
      #1 n++;
    end
    check8(8'(n < 40), 8'h01);
    check8(8'(cmd_ready), 8'h01);
    q = rsp_rdata;
  endtask : host_cmd

  task automatic side_access(input logic cs_n, input logic [7:0] a, d, output int n);
    @(posedge clk_in);
    #1 side_if.chip_select_n = cs_n;
    side_if.addr = a;
    side_if.data_host = d;
    side_if.data_host_oe = 1'b1;
    repeat (3) @(posedge clk_in);
    #1 side_if.write_or_direction_pin = 1'b0;
    n = 0;
    while (side_if.transfer_acknowledge_n !== 1'b0 && n < 6) begin
      @(posedge clk_in);
      #1 n++;
    end
    if (n < 6) check8(8'(side_busy), 8'h01);
    side_if.write_or_direction_pin = 1'b1;
    repeat (4) @(posedge clk_in);
    #1 check8(8'(side_if.transfer_acknowledge_n), 8'h01);
    side_if.chip_select_n = 1'b1;
    side_if.data_host_oe = 1'b0;
  endtask : side_access

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_values();
    logic [7:0] a [3] = '{8'h00, 8'h80, 8'hFF};
    foreach (a[i]) begin
      host_cmd(STYLE_SEPARATE, 1'b0, a[i], 8'h00);
      check8(q, REG_RESET);
    end
  endtask : t_reset_values

  task automatic t_write_read(input logic [1:0] st, input logic [7:0] key);
    logic [7:0] a [3] = '{8'h00, 8'h5A, 8'hFF};
    int s0;
    foreach (a[i]) begin
      s0 = wr_seen;
      host_cmd(st, 1'b1, a[i], a[i] ^ key);
      check8(wr_addr, a[i]);
      check8(wr_data, a[i] ^ key);
      check8(8'(wr_seen - s0), 8'h01);
      check8(q, a[i] ^ key);
    end
    foreach (a[i]) begin
      host_cmd(st, 1'b0, a[i], 8'h00);
      check8(q, a[i] ^ key);
    end
  endtask : t_write_read

  // back to separate strobes: data written in direction mode reads back
  task automatic t_style_back();
    host_cmd(STYLE_SEPARATE, 1'b0, 8'h5A, 8'h00);
    check8(q, 8'h5A ^ 8'h3C);
  endtask : t_style_back

  task automatic t_side();
    int n, s0;
    s0 = side_seen;
    side_access(1'b1, 8'h33, 8'h99, n);
    check8(8'(n), 8'h06);
    check8(8'(side_seen - s0), 8'h00);
    side_access(1'b0, 8'h44, 8'h66, n);
    check8(8'(n <= ACK_MAX_CYC), 8'h01);
    check8(side_addr, 8'h44);
    check8(side_data, 8'h66);
    check8(8'(side_seen - s0), 8'h01);
    for (int st = 2; st < 4; st++) begin
      side_style = 2'(st);
      side_access(1'b0, 8'h55, 8'h77, n);
      check8(8'(n), 8'h06);
    end
    side_style = STYLE_SEPARATE;
  endtask : t_side

  task automatic finish_test();
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    reset_in = 1'b1;
    style = STYLE_SEPARATE;
    side_style = STYLE_SEPARATE;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 8'h00;
    cmd_wdata = 8'h00;
    side_if.chip_select_n = 1'b1;
    side_if.addr = 8'h00;
    // latch strobe tied high on the side link: address passes straight through
    side_if.address_strobe_in = 1'b1;
    side_if.read_or_data_strobe_pin = 1'b1;
    side_if.write_or_direction_pin = 1'b1;
    side_if.data_host = 8'h00;
    side_if.data_host_oe = 1'b0;
    repeat (20) @(posedge clk_in);
    #1 reset_in = 1'b0;
    t_reset_values();
    t_write_read(STYLE_SEPARATE, 8'hA5);
    t_write_read(STYLE_DIRPIN, 8'h3C);
    t_style_back();
    t_side();
    finish_test();
  end
endmodule : tb_async_parallel_host_port
`default_nettype wire
